// [include/frt_pkg.sv]
// Constants, types and helpers shared by the range and trim block
// Summary of operation
// - Range 11, wide: factor 2560, 80-100 MHz.
// - Two-bit range select picks range, resets 00.
// - Low-power bit set blocks range select writes.
// - Read-only status shows range in effect.
// - Status lags write through oscillator-domain synchroniser.
// - Fast trim bits 4:1, larger code longer.
// - Fast trim loads factory value on first edge after reset release.
// - Bit 0 slow fine trim, factory loaded.
// - Control five bit 7 reads zero.
package frt_pkg;
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CGC5 = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_CFG = 4'hc;
  localparam int unsigned POS_SLOW_TRIM = 0;
  localparam int unsigned POS_FAST_LSB = 1;
  localparam int unsigned POS_RANGE_LSB = 5;
  localparam int unsigned POS_NARROW = 7;
  localparam int unsigned POS_LOW_POWER = 0;
  localparam logic [1:0] RANGE_RESET = 2'h0;
  localparam logic [3:0] FAST_TRIM_RESET = 4'h8;
  localparam logic SLOW_TRIM_RESET = 1'b0;
  // ****************************************
  // Timing counts, in clock cycles, and counter width
  // ****************************************
  localparam int unsigned OSC_DIV = 4;
  localparam int unsigned FAST_BASE_CYC = 16;
  localparam int unsigned SLOW_BASE_CYC = 3000;
  localparam int unsigned CNT_W = 12;
  // ****************************************
  // Multiplication factors per range
  // ****************************************
  localparam logic [11:0] FACTOR_LOW = 12'd640;
  localparam logic [11:0] FACTOR_LOW_N = 12'd732;
  localparam logic [11:0] FACTOR_MID = 12'd1280;
  localparam logic [11:0] FACTOR_MID_N = 12'd1464;
  localparam logic [11:0] FACTOR_MHI = 12'd1920;
  localparam logic [11:0] FACTOR_MHI_N = 12'd2197;
  localparam logic [11:0] FACTOR_HIGH = 12'd2560;
  localparam logic [11:0] FACTOR_HIGH_N = 12'd2929;

  typedef enum logic [1:0] {
    RANGE_LOW = 2'h0,
    RANGE_MID = 2'h1,
    RANGE_MHI = 2'h2,
    RANGE_HIGH = 2'h3
  } frt_range_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } frt_avs_req_t;

  function automatic logic [11:0] fll_factor(input logic [1:0] r, input logic narrow);
    logic [11:0] f;
    f = FACTOR_LOW;
    unique case (frt_range_t'(r))
      RANGE_LOW: f = narrow ? FACTOR_LOW_N : FACTOR_LOW;
      RANGE_MID: f = narrow ? FACTOR_MID_N : FACTOR_MID;
      RANGE_MHI: f = narrow ? FACTOR_MHI_N : FACTOR_MHI;
      RANGE_HIGH: f = narrow ? FACTOR_HIGH_N : FACTOR_HIGH;
    endcase
    return f;
  endfunction
endpackage

// [logic/frt_range_xfer.sv]
// Two-stage synchroniser carrying the range code into the oscillator domain
`timescale 1ns/1ps
`default_nettype none
module frt_range_xfer #(
  parameter int unsigned W = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Oscillator-domain enable
  input wire logic osc_tick,
  // Range code
  input wire logic [W-1:0] range_in,
  output logic [W-1:0] range_out
);
  logic [W-1:0] stage1_r;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1_r <= '0;
      range_out <= '0;
    end else if (osc_tick) begin
      stage1_r <= range_in;
      range_out <= stage1_r;
    end
  end
endmodule
`default_nettype wire

// [logic/frt_top.sv]
// Range select, range status and reference trim registers on Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module frt_top #(
  parameter int unsigned OSC_DIV = frt_pkg::OSC_DIV,
  parameter int unsigned FAST_BASE_CYC = frt_pkg::FAST_BASE_CYC,
  parameter int unsigned SLOW_BASE_CYC = frt_pkg::SLOW_BASE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Avalon-MM slave
  input wire frt_pkg::frt_avs_req_t avs_req,
  output logic [31:0] avs_readdata_r,
  output logic avs_waitrequest_r,
  // Factory trim values
  input wire logic [3:0] factory_fast_trim,
  input wire logic factory_slow_trim,
  // Oscillator and reference outputs
  output logic [1:0] range_status,
  output logic [11:0] fll_factor_r,
  output logic fast_ref_tick_r,
  output logic slow_ref_tick_r
);
  // ****************************************
  // Register state
  // ****************************************
  logic [1:0] range_select_r;
  logic [1:0] range_select_nxt;
  logic narrow_range_option_r;
  logic [3:0] fast_ref_trim_r;
  logic slow_ref_fine_trim_r;
  logic low_power_bit_r;
  logic load_pending_r;
  logic [frt_pkg::CNT_W-1:0] osc_cnt_r;
  logic osc_tick_r;
  logic [frt_pkg::CNT_W-1:0] fast_cnt_r;
  logic [frt_pkg::CNT_W-1:0] slow_cnt_r;

  // ****************************************
  // Bus decode
  // ****************************************
  wire req = avs_req.read | avs_req.write;
  wire req_seen = req & avs_waitrequest_r;
  wire accept_wr = avs_req.write & ~avs_waitrequest_r;
  wire wr_ctrl = accept_wr & (avs_req.address == frt_pkg::OFS_CTRL);
  wire wr_cfg = accept_wr & (avs_req.address == frt_pkg::OFS_CFG);
  wire [31:0] wd = avs_req.writedata;
  wire [31:0] ctrl_word = {24'h0, narrow_range_option_r, range_select_r, fast_ref_trim_r, slow_ref_fine_trim_r};
  wire [31:0] stat_word = {30'h0, range_status};
  wire [31:0] cfg_word = {31'h0, low_power_bit_r};
  // Neighbouring fields of control five live elsewhere; bit 7 is fixed zero
  wire [31:0] cgc5_word = 32'h0;
  wire [31:0] rd_word = (avs_req.address == frt_pkg::OFS_CTRL) ? ctrl_word :
                        (avs_req.address == frt_pkg::OFS_CGC5) ? cgc5_word :
                        (avs_req.address == frt_pkg::OFS_STAT) ? stat_word :
                        (avs_req.address == frt_pkg::OFS_CFG) ? cfg_word : 32'h0;
  // Low-power mode freezes the range
  assign range_select_nxt = (wr_ctrl && !low_power_bit_r) ?
                            wd[frt_pkg::POS_RANGE_LSB +: 2] : range_select_r;

  // Two-edge handshake: waitrequest drops for one cycle per request
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest_r <= 1'b1;
      avs_readdata_r <= 32'h0;
    end else begin
      avs_waitrequest_r <= ~req_seen;
      if (req_seen) begin
        avs_readdata_r <= rd_word;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      range_select_r <= frt_pkg::RANGE_RESET;
      narrow_range_option_r <= 1'b0;
      low_power_bit_r <= 1'b0;
    end else begin
      range_select_r <= range_select_nxt;
      if (wr_ctrl) begin
        narrow_range_option_r <= wd[frt_pkg::POS_NARROW];
      end
      if (wr_cfg) begin
        low_power_bit_r <= wd[frt_pkg::POS_LOW_POWER];
      end
    end
  end

  // Factory trims are caught on the first edge after release, not by the reset itself
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      load_pending_r <= 1'b1;
      fast_ref_trim_r <= frt_pkg::FAST_TRIM_RESET;
      slow_ref_fine_trim_r <= frt_pkg::SLOW_TRIM_RESET;
    end else if (load_pending_r) begin
      load_pending_r <= 1'b0;
      fast_ref_trim_r <= factory_fast_trim;
      slow_ref_fine_trim_r <= factory_slow_trim;
    end else if (wr_ctrl) begin
      fast_ref_trim_r <= wd[frt_pkg::POS_FAST_LSB +: 4];
      slow_ref_fine_trim_r <= wd[frt_pkg::POS_SLOW_TRIM];
    end
  end

  // ****************************************
  // Oscillator domain and range status
  // ****************************************
  wire osc_wrap = (osc_cnt_r == frt_pkg::CNT_W'(OSC_DIV - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_r <= '0;
      osc_tick_r <= 1'b0;
    end else begin
      osc_cnt_r <= osc_wrap ? '0 : osc_cnt_r + 1'b1;
      osc_tick_r <= osc_wrap;
    end
  end

  frt_range_xfer #(.W(2)) u_xfer (
    .clock(clock),
    .nrst(nrst),
    .osc_tick(osc_tick_r),
    .range_in(range_select_r),
    .range_out(range_status)
  );

  // Factor follows the range in effect, not the freshly written one
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fll_factor_r <= frt_pkg::FACTOR_LOW;
    end else begin
      fll_factor_r <= frt_pkg::fll_factor(range_status, narrow_range_option_r);
    end
  end

  // ****************************************
  // Reference clock period generators
  // ****************************************
  // Binary weighted: trim bit i adds 2**i cycles to the period
  wire [frt_pkg::CNT_W-1:0] fast_period = frt_pkg::CNT_W'(FAST_BASE_CYC) + {8'h0, fast_ref_trim_r};
  wire [frt_pkg::CNT_W-1:0] slow_period = frt_pkg::CNT_W'(SLOW_BASE_CYC) + {11'h0, slow_ref_fine_trim_r};
  wire fast_wrap = (fast_cnt_r >= fast_period - 1'b1);
  wire slow_wrap = (slow_cnt_r >= slow_period - 1'b1);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fast_cnt_r <= '0;
      slow_cnt_r <= '0;
      fast_ref_tick_r <= 1'b0;
      slow_ref_tick_r <= 1'b0;
    end else begin
      fast_cnt_r <= fast_wrap ? '0 : fast_cnt_r + 1'b1;
      slow_cnt_r <= slow_wrap ? '0 : slow_cnt_r + 1'b1;
      fast_ref_tick_r <= fast_wrap;
      slow_ref_tick_r <= slow_wrap;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence ctrl_write_s;
    wr_ctrl;
  endsequence

  sequence range_change_s;
    range_select_r != $past(range_select_r);
  endsequence

  property high_wide_p;
    @(posedge clock) disable iff (!nrst)
      (range_status == 2'h3 && !narrow_range_option_r) |=> (fll_factor_r == 12'd2560);
  endproperty

  property high_narrow_p;
    @(posedge clock) disable iff (!nrst)
      (range_status == 2'h3 && narrow_range_option_r) |=> (fll_factor_r == 12'd2929);
  endproperty

  high_wide_a: assert property (high_wide_p) else $error("high wide factor wrong");
  high_narrow_a: assert property (high_narrow_p) else $error("high narrow factor wrong");

  low_range_a: assert property (@(posedge clock) disable iff (!nrst)
    (range_status == 2'h0 && !narrow_range_option_r) |=> (fll_factor_r == 12'd640))
    else $error("low range factor wrong");

  lp_freeze_a: assert property (@(posedge clock) disable iff (!nrst)
    (wr_ctrl && low_power_bit_r) |=> $stable(range_select_r))
    else $error("range changed in low power");

  status_follow_a: assert property (@(posedge clock) disable iff (!nrst)
    range_change_s |-> ##[1:12] (range_status == range_select_r))
    else $error("status did not follow select");

  status_lag_a: assert property (@(posedge clock) disable iff (!nrst)
    (ctrl_write_s ##1 range_change_s) |-> (range_status != range_select_r) ##1 (range_status != range_select_r))
    else $error("status updated too soon");

  // A shortened trim may leave the count past its end, so only in-range counts are judged
  fast_period_a: assert property (@(posedge clock) disable iff (!nrst)
    (fast_cnt_r <= fast_period - 1'b1) |=> (fast_ref_tick_r == ($past(fast_cnt_r) == $past(fast_period) - 1'b1)))
    else $error("fast period wrong");

  // Sampled reset level keeps the release edge itself out of the antecedent
  factory_load_a: assert property (@(posedge clock) disable iff (!nrst)
    (nrst && load_pending_r) |=> (fast_ref_trim_r == $past(factory_fast_trim)) && !load_pending_r)
    else $error("fast trim not loaded");

  slow_load_a: assert property (@(posedge clock) disable iff (!nrst)
    (nrst && load_pending_r) |=> (slow_ref_fine_trim_r == $past(factory_slow_trim)))
    else $error("slow trim not loaded");

  rsv_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    (avs_req.read && !avs_waitrequest_r && avs_req.address == frt_pkg::OFS_CGC5) |-> (avs_readdata_r[7] == 1'b0))
    else $error("reserved bit reads one");

  slow_period_a: assert property (@(posedge clock) disable iff (!nrst)
    (slow_cnt_r <= slow_period - 1'b1) |=> (slow_ref_tick_r == ($past(slow_cnt_r) == $past(slow_period) - 1'b1)))
    else $error("slow period wrong");
endmodule
`default_nettype wire

// [verif/frt_top_tb_top.sv]
// Self-checking bench for the range select and reference trim block
`timescale 1ns/1ps
`default_nettype none
module frt_top_tb_top;
  // ****************************************
  // Signals and instance
  // ****************************************
  localparam int unsigned SLOW_B = 20;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  frt_pkg::frt_avs_req_t avs_req = '0;
  logic [31:0] avs_readdata_r;
  logic avs_waitrequest_r;
  logic [3:0] factory_fast_trim = 4'ha;
  logic factory_slow_trim = 1'b1;
  logic [1:0] range_status;
  logic [11:0] fll_factor_r;
  logic fast_ref_tick_r;
  logic slow_ref_tick_r;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  int n;
  logic [11:0] factors [8] = '{12'd640, 12'd732, 12'd1280, 12'd1464, 12'd1920, 12'd2197, 12'd2560, 12'd2929};
  always #5 clock = ~clock;
  frt_top #(.OSC_DIV(frt_pkg::OSC_DIV), .FAST_BASE_CYC(frt_pkg::FAST_BASE_CYC), .SLOW_BASE_CYC(SLOW_B)) i_frt_top (
    .clock(clock), .nrst(nrst), .avs_req(avs_req), .avs_readdata_r(avs_readdata_r),
    .avs_waitrequest_r(avs_waitrequest_r), .factory_fast_trim(factory_fast_trim),
    .factory_slow_trim(factory_slow_trim), .range_status(range_status), .fll_factor_r(fll_factor_r),
    .fast_ref_tick_r(fast_ref_tick_r), .slow_ref_tick_r(slow_ref_tick_r));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Waits one edge first so a released request never re-rises in the same step
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] wdata, output logic [31:0] data);
    @(posedge clock);
    avs_req.read <= ~wr;
    avs_req.write <= wr;
    avs_req.address <= addr;
    avs_req.writedata <= {24'h0, wdata};
    do begin
      @(posedge clock);
    end while (avs_waitrequest_r !== 1'b0);
    data = avs_readdata_r;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] addr, input logic [7:0] wdata);
    logic [31:0] d;
    bus(1'b1, addr, wdata, d);
  endtask
  task automatic rd8(input logic [3:0] addr, output logic [31:0] data);
    bus(1'b0, addr, 8'h0, data);
    data = {24'h0, data[7:0]};
  endtask
  // Skips the first two periods, the first of which may straddle the trim write
  task automatic period(input logic slow, output int cnt);
    int seen;
    seen = 0;
    cnt = 0;
    while (seen < 3) begin
      @(posedge clock);
      if (seen == 2) cnt++;
      if ((slow ? slow_ref_tick_r : fast_ref_tick_r) === 1'b1) seen++;
    end
  endtask
  // ****************************************
  // Timeout and main sequence
  // ****************************************
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    rd8(frt_pkg::OFS_CTRL, rd);
    check(rd, 32'h15, "factory trims and reset range");
    check({30'h0, range_status}, 32'h0, "reset status");
    $display("test reset done");
    wr(frt_pkg::OFS_CGC5, 8'hff);
    rd8(frt_pkg::OFS_CGC5, rd);
    check(rd, 32'h0, "control five bit 7");
    rd8(4'h2, rd);
    check(rd, 32'h0, "unmapped read");
    $display("test reserved done");
    for (int k = 0; k < 8; k++) begin
      logic [1:0] r;
      logic [1:0] prev;
      logic nb;
      r = 2'((k >> 1) + 1);
      nb = k[0];
      prev = range_status;
      wr(frt_pkg::OFS_CTRL, {nb, r, 4'ha, 1'b1});
      #1;
      if (nb == 1'b0) check({30'h0, range_status}, {30'h0, prev}, "status lags write");
      repeat (12) @(posedge clock);
      rd8(frt_pkg::OFS_STAT, rd);
      check(rd, {30'h0, r}, "range status");
      check({20'h0, fll_factor_r}, {20'h0, factors[{r, nb}]}, "factor");
    end
    $display("test ranges done");
    wr(frt_pkg::OFS_CFG, 8'h01);
    wr(frt_pkg::OFS_CTRL, 8'h46);
    rd8(frt_pkg::OFS_CTRL, rd);
    check(rd, 32'h06, "range write blocked, trim written");
    repeat (12) @(posedge clock);
    check({30'h0, range_status}, 32'h0, "status held in low power");
    period(1'b0, n);
    check(n, frt_pkg::FAST_BASE_CYC + 3, "fast period trim 3");
    period(1'b1, n);
    check(n, SLOW_B, "slow period fine clear");
    wr(frt_pkg::OFS_CTRL, 8'h1f);
    period(1'b0, n);
    check(n, frt_pkg::FAST_BASE_CYC + 15, "fast period trim 15");
    period(1'b1, n);
    check(n, SLOW_B + 1, "slow period fine set");
    $display("test low power and trims done");
    wr(frt_pkg::OFS_CFG, 8'h00);
    wr(frt_pkg::OFS_CTRL, 8'h5f);
    repeat (12) @(posedge clock);
    rd8(frt_pkg::OFS_STAT, rd);
    check(rd, 32'h2, "range after low power clear");
    check({20'h0, fll_factor_r}, {20'h0, factors[4]}, "factor mid-high");
    $display("test release done");
    summarize();
  end
endmodule
`default_nettype wire
